//--- rtl/lbps_pkg.sv
package lbps_pkg;

  // clock and tick base
  localparam int CLK_MHZ          = 200;
  localparam int TICK_US          = 500;
  localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam int TICK_W           = 17;
  localparam int TMR_W            = 8;

  // timing figures in their own units, then in ticks
  localparam int UV_QUAL_MS       = 50;
  localparam int UV_QUAL_TICKS    = UV_QUAL_MS * 1000 / TICK_US;
  localparam int RESET_STEP_MS    = 2;
  localparam int RESET_STEP_TICKS = RESET_STEP_MS * 1000 / TICK_US;
  localparam int SRC_DELAY_MAX_MS = 70;
  localparam int TICKS_PER_MS     = 1000 / TICK_US;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_SOFT   = 5'h04;
  localparam logic [4:0] OFS_DELAY  = 5'h08;
  localparam logic [4:0] OFS_GATE   = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // field positions
  localparam int CTRL_IO_LSB    = 0;
  localparam int CTRL_LDO_BIT   = 2;
  localparam int CTRL_RSEL_BIT  = 3;
  localparam int SOFT_LOGIC_LSB = 0;
  localparam int SOFT_BIAS_LSB  = 4;
  localparam int DLY_SRC_LSB    = 0;
  localparam int DLY_RST_LSB    = 8;
  localparam int GATE_HOT_LSB   = 0;
  localparam int GATE_COLD_LSB  = 4;

  // io voltage select codes
  localparam logic [1:0] IO_SEL_1V7 = 2'h0;
  localparam logic [1:0] IO_SEL_1V8 = 2'h1;
  localparam logic [1:0] IO_SEL_2V5 = 2'h2;

  localparam int NRAILS = 5;

  typedef struct packed {
    logic gate;
    logic source;
    logic io2;
    logic io1;
    logic core;
  } lbps_rails_t;

  typedef struct packed {
    logic [1:0] io_voltage_select;
    logic       ldo_select;
    logic       reset_threshold_select;
    logic [2:0] logic_rail_softstart_time;
    logic [2:0] bias_rail_softstart_time;
    logic [6:0] source_boost_start_delay;
    logic [2:0] reset_pulse_duration;
    logic [3:0] gate_high_hot_target;
    logic [3:0] gate_high_cold_target;
  } lbps_cfg_t;

  localparam lbps_cfg_t CFG_RESET = '{
    io_voltage_select:         IO_SEL_1V7,
    ldo_select:                1'b0,
    reset_threshold_select:    1'b0,
    logic_rail_softstart_time: 3'h0,
    bias_rail_softstart_time:  3'h0,
    source_boost_start_delay:  7'h00,
    reset_pulse_duration:      3'h0,
    gate_high_hot_target:      4'h0,
    gate_high_cold_target:     4'h0
  };

  typedef enum logic [4:0] {
    ST_OFF   = 5'b00001,
    ST_LOGIC = 5'b00010,
    ST_SRC   = 5'b00100,
    ST_GATE  = 5'b01000,
    ST_FAULT = 5'b10000
  } lbps_state_t;

endpackage : lbps_pkg

//--- rtl/lbps_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - io1 rail starts with core and ldo
// - outside fault, lockout drops io1 and turns on discharge
// - ldo only when io1 is 2.5 V
// - logic soft-start setting shared, 0.5-4 ms
// - gate rail waits for source rail ramp
// - bias soft-start setting shared, 4-7.5 ms
// - gate rail off on enable low, latched
// - gate cold and hot targets separately programmable
// - below 70 percent over 50 ms faults
// - below 30 percent faults at once
// - faults cleared only by power-on reset, not by lockout
// - reset held 2-16 ms after core ramp
// - released reset stays high until power-down or fault
// - select lockout or detect for reset reassert
// - reset pin is open-drain pulldown
// - source rail starts after programmable 0-70 ms delay
// - source rail off on enable low, latched
// - io1 selectable 1.7, 1.8, 2.5 V
module lbps_sequencer
  import lbps_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES     // cycles per 0.5 ms tick
) (
  input  wire logic              clk,              // 200 MHz clock
  input  wire logic              rst,              // supply power-on reset
  input  wire logic [4:0]        avs_address,      // byte address
  input  wire logic              avs_read,         // read request
  input  wire logic              avs_write,        // write request
  input  wire logic [31:0]       avs_writedata,    // write data
  input  wire logic [3:0]        avs_byteenable,   // write byte lanes
  output logic [31:0]            avs_readdata,     // read data
  output logic                   avs_waitrequest,  // stall
  input  wire logic              enable_pin,       // host enable pin
  input  wire logic              supply_ok,        // supply above lockout
  input  wire logic              above_detect,     // supply above detect threshold
  input  wire logic [NRAILS-1:0] ramp_done,        // per rail ramp complete
  input  wire logic [NRAILS-1:0] below70,          // per rail under 70 percent
  input  wire logic [NRAILS-1:0] below30,          // per rail under 30 percent
  input  wire logic              reset_line_in,    // reset pin level
  output logic                   reset_line_out,   // reset pin drive value
  output logic                   reset_line_oe,    // reset pin pulldown on
  output lbps_rails_t            rail_en,          // per rail enables
  output logic                   io1_discharge,    // io1 active discharge
  output logic                   chip_shutdown,    // global fault shutdown
  output lbps_cfg_t              cfg               // settings to analog
);

  // pin synchronisers: enable, supply ok, detect, reset line
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {reset_line_in, above_detect, supply_ok, enable_pin};
      sync2_q <= sync1_q;
    end
  end

  logic en_s;
  logic sup_s;
  logic det_s;
  logic line_s;
  assign en_s   = sync2_q[0];
  assign sup_s  = sync2_q[1];
  assign det_s  = sync2_q[2];
  assign line_s = sync2_q[3];

  // 0.5 ms tick divider
  logic [TICK_W-1:0] div_q;
  logic [TICK_W-1:0] div_d;
  logic              tick_q;
  logic              tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d  = div_q + 1'b1;
    if (div_q == TICK_W'(TICK_CYC - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : lane_merge

  function automatic logic [6:0] clamp_delay(input logic [6:0] v);
    return (v > 7'(SRC_DELAY_MAX_MS)) ? 7'(SRC_DELAY_MAX_MS) : v;
  endfunction : clamp_delay

  // register images as bus words
  lbps_cfg_t   cfg_q;
  lbps_cfg_t   cfg_d;
  logic [31:0] w_ctrl;
  logic [31:0] w_soft;
  logic [31:0] w_dly;
  logic [31:0] w_gate;
  logic [31:0] w_stat;

  lbps_state_t state_q;
  lbps_state_t state_d;
  lbps_rails_t rails_q;
  lbps_rails_t rails_d;
  logic [NRAILS-1:0] up_q;
  logic [NRAILS-1:0] up_d;
  logic        uv_fault_q;
  logic        uv_fault_d;
  logic        sc_fault_q;
  logic        sc_fault_d;
  logic        src_off_q;
  logic        src_off_d;
  logic        gate_off_q;
  logic        gate_off_d;
  logic        released_q;
  logic        released_d;
  logic        oe_q;
  logic        oe_d;
  logic        dis_q;
  logic        dis_d;
  logic        shut_q;
  logic        shut_d;

  always_comb begin
    w_ctrl = '0;
    w_ctrl[CTRL_IO_LSB +: 2]  = cfg_q.io_voltage_select;
    w_ctrl[CTRL_LDO_BIT]      = cfg_q.ldo_select;
    w_ctrl[CTRL_RSEL_BIT]     = cfg_q.reset_threshold_select;
    w_soft = '0;
    w_soft[SOFT_LOGIC_LSB +: 3] = cfg_q.logic_rail_softstart_time;
    w_soft[SOFT_BIAS_LSB +: 3]  = cfg_q.bias_rail_softstart_time;
    w_dly = '0;
    w_dly[DLY_SRC_LSB +: 7] = cfg_q.source_boost_start_delay;
    w_dly[DLY_RST_LSB +: 3] = cfg_q.reset_pulse_duration;
    w_gate = '0;
    w_gate[GATE_HOT_LSB +: 4]  = cfg_q.gate_high_hot_target;
    w_gate[GATE_COLD_LSB +: 4] = cfg_q.gate_high_cold_target;
    w_stat = {14'h0, sup_s, en_s, line_s, released_q, gate_off_q, src_off_q,
              sc_fault_q, uv_fault_q, rails_q, state_q};
  end

  // avalon slave: one wait cycle, then answer
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wr_go;
  logic [31:0] wv;

  assign wr_go = avs_write && !wait_q;

  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    cfg_d   = cfg_q;
    wv      = '0;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
    end
    if (avs_read && wait_q) begin
      case (avs_address)
        OFS_CTRL:   rdata_d = w_ctrl;
        OFS_SOFT:   rdata_d = w_soft;
        OFS_DELAY:  rdata_d = w_dly;
        OFS_GATE:   rdata_d = w_gate;
        OFS_STATUS: rdata_d = w_stat;
        default:    rdata_d = '0;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        OFS_CTRL: begin
          wv = lane_merge(w_ctrl, avs_writedata, avs_byteenable);
          cfg_d.io_voltage_select      = wv[CTRL_IO_LSB +: 2];
          cfg_d.ldo_select             = wv[CTRL_LDO_BIT];
          cfg_d.reset_threshold_select = wv[CTRL_RSEL_BIT];
        end
        OFS_SOFT: begin
          wv = lane_merge(w_soft, avs_writedata, avs_byteenable);
          cfg_d.logic_rail_softstart_time = wv[SOFT_LOGIC_LSB +: 3];
          cfg_d.bias_rail_softstart_time  = wv[SOFT_BIAS_LSB +: 3];
        end
        OFS_DELAY: begin
          wv = lane_merge(w_dly, avs_writedata, avs_byteenable);
          cfg_d.source_boost_start_delay = clamp_delay(wv[DLY_SRC_LSB +: 7]);
          cfg_d.reset_pulse_duration     = wv[DLY_RST_LSB +: 3];
        end
        OFS_GATE: begin
          wv = lane_merge(w_gate, avs_writedata, avs_byteenable);
          cfg_d.gate_high_hot_target  = wv[GATE_HOT_LSB +: 4];
          cfg_d.gate_high_cold_target = wv[GATE_COLD_LSB +: 4];
        end
        default: wv = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      cfg_q   <= CFG_RESET;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      cfg_q   <= cfg_d;
    end
  end

  // timers: reset pulse, source start delay, per rail undervoltage
  logic [TMR_W-1:0]  rst_limit;
  logic [TMR_W-1:0]  src_limit;
  logic              rst_run;
  logic              src_run;
  logic              rst_exp;
  logic              src_exp;
  logic [NRAILS-1:0] uv_run;
  logic [NRAILS-1:0] uv_exp;

  assign rst_limit = TMR_W'((cfg_q.reset_pulse_duration + 4'h1) * RESET_STEP_TICKS);
  assign src_limit = TMR_W'(cfg_q.source_boost_start_delay * TICKS_PER_MS);
  assign rst_run   = (state_q != ST_OFF) && (state_q != ST_FAULT) && up_q[0];
  assign src_run   = (state_q == ST_LOGIC) && en_s && released_q;

  lbps_tick_timer u_rst_tmr (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_q),
    .run     (rst_run),
    .limit   (rst_limit),
    .expired (rst_exp)
  );

  lbps_tick_timer u_src_tmr (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_q),
    .run     (src_run),
    .limit   (src_limit),
    .expired (src_exp)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NRAILS; gi++) begin : g_uv
      assign uv_run[gi] = rails_q[gi] && up_q[gi] && below70[gi];
      lbps_tick_timer u_uv_tmr (
        .clk     (clk),
        .rst     (rst),
        .tick    (tick_q),
        .run     (uv_run[gi]),
        .limit   (TMR_W'(UV_QUAL_TICKS)),
        .expired (uv_exp[gi])
      );
    end
  endgenerate

  // sequencer
  logic sc_now;
  logic pd_thresh;
  assign sc_now    = |(rails_q & up_q & below30);
  assign pd_thresh = cfg_q.reset_threshold_select ? !det_s : !sup_s;

  always_comb begin
    state_d    = state_q;
    up_d       = up_q | (rails_q & ramp_done);
    uv_fault_d = uv_fault_q | (|uv_exp);
    sc_fault_d = sc_fault_q | sc_now;
    src_off_d  = src_off_q;
    gate_off_d = gate_off_q;
    released_d = released_q;
    case (state_q)
      ST_OFF: begin
        up_d = '0;
        if (sup_s) begin
          state_d = ST_LOGIC;
        end
      end
      ST_LOGIC: begin
        if (src_exp && !src_off_q) begin
          state_d = ST_SRC;
        end
      end
      ST_SRC: begin
        if (!en_s) begin
          src_off_d = 1'b1;
        end
        if (up_q[3]) begin
          state_d = ST_GATE;
        end
      end
      ST_GATE: begin
        if (!en_s) begin
          src_off_d  = 1'b1;
          gate_off_d = 1'b1;
        end
      end
      ST_FAULT: state_d = ST_FAULT;
      default:  state_d = ST_OFF;
    endcase
    if (state_q != ST_FAULT && !sup_s) begin
      state_d = ST_OFF;
    end
    if (uv_fault_d || sc_fault_d) begin
      state_d = ST_FAULT;
    end
    if (rst_exp) begin
      released_d = 1'b1;
    end
    if (pd_thresh || state_q == ST_FAULT) begin
      released_d = 1'b0;
    end
    rails_d        = '0;
    rails_d.core   = (state_d != ST_OFF) && (state_d != ST_FAULT);
    rails_d.io1    = rails_d.core;
    rails_d.io2    = rails_d.core && (cfg_q.io_voltage_select == IO_SEL_2V5);
    rails_d.source = ((state_d == ST_SRC) || (state_d == ST_GATE))
                     && !src_off_d && en_s;
    rails_d.gate   = (state_d == ST_GATE) && !gate_off_d && en_s;
    dis_d          = (state_d == ST_OFF);
    shut_d         = (state_d == ST_FAULT);
    oe_d           = !released_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_OFF;
      up_q       <= '0;
      uv_fault_q <= 1'b0;
      sc_fault_q <= 1'b0;
      src_off_q  <= 1'b0;
      gate_off_q <= 1'b0;
      released_q <= 1'b0;
      rails_q    <= '0;
      dis_q      <= 1'b1;
      shut_q     <= 1'b0;
      oe_q       <= 1'b1;
    end else begin
      state_q    <= state_d;
      up_q       <= up_d;
      uv_fault_q <= uv_fault_d;
      sc_fault_q <= sc_fault_d;
      src_off_q  <= src_off_d;
      gate_off_q <= gate_off_d;
      released_q <= released_d;
      rails_q    <= rails_d;
      dis_q      <= dis_d;
      shut_q     <= shut_d;
      oe_q       <= oe_d;
    end
  end

  // pin drives low only; pullup is external
  assign reset_line_out  = 1'b0;
  assign reset_line_oe   = oe_q;
  assign rail_en         = rails_q;
  assign io1_discharge   = dis_q;
  assign chip_shutdown   = shut_q;
  assign cfg             = cfg_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule : lbps_sequencer

//--- rtl/lbps_tick_timer.sv
`timescale 1ns/1ps
module lbps_tick_timer
  import lbps_pkg::*;
(
  input  wire logic             clk,     // system clock
  input  wire logic             rst,     // async reset, active high
  input  wire logic             tick,    // base tick enable
  input  wire logic             run,     // count while high, clear when low
  input  wire logic [TMR_W-1:0] limit,   // ticks to expiry
  output logic                  expired  // level, high once limit reached
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             exp_q;
  logic             exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (!run) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (cnt_q >= limit) begin
      exp_d = 1'b1;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule : lbps_tick_timer

//--- verif/lbps_seq_chk.sv
`timescale 1ns/1ps
module lbps_seq_chk
  import lbps_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES  // cycles per tick
) (
  input wire logic              clk,             // clock
  input wire logic              rst,             // reset
  input wire logic              avs_read,        // bus read
  input wire logic              avs_write,       // bus write
  input wire logic              avs_waitrequest, // bus stall
  input wire logic [NRAILS-1:0] ramp_done,       // ramp flags
  input wire logic [NRAILS-1:0] below70,         // uv flags
  input wire logic [NRAILS-1:0] below30,         // short flags
  input wire logic              reset_line_out,  // pin value
  input wire logic              reset_line_oe,   // pin pulldown
  input wire lbps_rails_t       rail_en,         // rail enables
  input wire logic              io1_discharge,   // io1 discharge
  input wire logic              chip_shutdown,   // fault
  input wire lbps_cfg_t         cfg              // settings
);
  localparam int UV_MAX = UV_QUAL_TICKS * TICK_CYC + 8;
  localparam int UV_MIN = (UV_QUAL_TICKS - 1) * TICK_CYC;
  logic [15:0]       hold_q, hold_d, uv_q, uv_d;
  logic [NRAILS-1:0] live;
  int                rst_lo;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  assign live   = rail_en & ramp_done;
  assign rst_lo = ((int'(cfg.reset_pulse_duration) + 1) * 4 - 1) * TICK_CYC;
  // cycles of reset hold with core up, and of continuous undervoltage
  always_comb begin
    hold_d = (reset_line_oe && rail_en.core && ramp_done[0]) ? hold_q + 16'h0001 : 16'h0000;
    uv_d   = |(live & below70) ? uv_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 16'h0000;
      uv_q   <= 16'h0000;
    end else begin
      hold_q <= hold_d;
      uv_q   <= uv_d;
    end
  end

  AST_OD_LOW: assert property (reset_line_out == 1'b0)
    else $error("reset pin drive value not low");
  AST_IO1_WITH_CORE: assert property (rail_en.io1 == rail_en.core)
    else $error("io1 rail not enabled with core rail");
  AST_DISCHARGE: assert property (io1_discharge == (!rail_en.io1 && !chip_shutdown))
    else $error("io1 discharge wrong");
  AST_LDO_2V5: assert property (rail_en.io2 |-> cfg.io_voltage_select == IO_SEL_2V5
    || $past(cfg.io_voltage_select) == IO_SEL_2V5 || $past(cfg.io_voltage_select, 2) == IO_SEL_2V5)
    else $error("ldo on without 2.5 V io selection");
  AST_GATE_AFTER_SRC: assert property ($rose(rail_en.gate) |-> rail_en.source && $past(ramp_done[3]))
    else $error("gate rail before source ramp done");
  AST_SRC_AFTER_RST: assert property ($rose(rail_en.source) |-> !reset_line_oe)
    else $error("source rail while reset held");
  AST_SHORT_NOW: assert property (|(live & below30) |-> ##[1:3] chip_shutdown)
    else $error("short not latched at once");
  AST_UV_LATE: assert property ((uv_q > UV_MAX) |-> chip_shutdown)
    else $error("undervoltage not latched in time");
  AST_UV_EARLY: assert property ($rose(chip_shutdown) |->
    ($past(below30) | $past(below30, 2)) != '0 || uv_q >= UV_MIN)
    else $error("fault latched too early");
  AST_FAULT_OFF: assert property (chip_shutdown |-> rail_en == '0)
    else $error("rails on during fault");
  AST_FAULT_HOLD: assert property (chip_shutdown |=> chip_shutdown)
    else $error("fault cleared without power cycle");
  AST_RST_HOLD: assert property ($fell(reset_line_oe) |->
    hold_q >= rst_lo && hold_q <= rst_lo + TICK_CYC + 8)
    else $error("reset hold time wrong");
  AST_WAIT_ONE: assert property (((avs_read || avs_write) && avs_waitrequest) |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait cycle");

  COV_FAULT: cover property ($rose(chip_shutdown));
  COV_GATE: cover property ($rose(rail_en.gate));
  COV_RELEASE: cover property ($fell(reset_line_oe));
endmodule : lbps_seq_chk

//--- verif/lbps_sequencer_tb_top.sv
`timescale 1ns/1ps
module lbps_sequencer_tb_top;
  import lbps_pkg::*;
  localparam int TC = 10;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} lbps_note_t;
  logic              clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]        avs_address = 5'h00;
  logic [31:0]       avs_writedata = 32'h0, avs_readdata, r;
  logic              avs_waitrequest, enable_pin = 1'b0, supply_ok = 1'b0;
  logic              above_detect = 1'b1, reset_line_out, reset_line_oe, reset_wire;
  logic [NRAILS-1:0] ramp_done = '0, below70 = '0, below30 = '0, ramp_hold = '0;
  logic              io1_discharge, chip_shutdown;
  lbps_rails_t       rail_en;
  lbps_cfg_t         cfg;
  lbps_note_t        note_q[$], nt;
  logic [6:0]        obs;
  int                err_count = 0, cmp_count = 0, n, seed = 32'hF815026E;
  logic [2:0]        rc;
  logic [6:0]        dl;

  always #2.5 clk = ~clk;
  assign obs = {chip_shutdown, reset_wire, rail_en};
  // analog stub: rails report ramped one cycle after enable
  always @(posedge clk) ramp_done <= rail_en & ~ramp_hold;

  lbps_sequencer #(.TICK_CYC(TC)) u_lbps_sequencer (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .enable_pin, .supply_ok, .above_detect, .ramp_done, .below70, .below30,
    .reset_line_in(reset_wire), .reset_line_out, .reset_line_oe, .rail_en, .io1_discharge,
    .chip_shutdown, .cfg);
  lbps_tcon_model u_lbps_tcon_model (.reset_line_out, .reset_line_oe, .reset_wire);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk(32'(k < 20), 32'h1);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
    note_q.push_back('{v & m, m});
    bus(1'b0, a, 32'h0);
  endtask : rd

  // read results checked against the oldest note
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && note_q.size() > 0) begin
      nt = note_q.pop_front();
      chk(avs_readdata & nt.m, nt.v);
    end
  end

  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wt

  task automatic pwr_up(input logic [2:0] c, input logic [6:0] d);
    rst          <= 1'b1;
    supply_ok    <= 1'b0;
    enable_pin   <= 1'b0;
    below70      <= '0;
    below30      <= '0;
    above_detect <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0, 32'hF);
    rd(OFS_STATUS, 32'h1, 32'h7FFF);
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_DELAY, {21'h0, c, 1'b0, d});
    supply_ok <= 1'b1;
    wt(5, 1'b1, 2000);
    chk(32'(n + TC >= (c + 1) * 4 * TC && n <= (c + 1) * 4 * TC + 20), 32'h1);
  endtask : pwr_up

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    rc = 3'($random(seed));
    dl = 7'($unsigned($random(seed)) % 6);
    r  = $random(seed);
    pwr_up(rc, dl);
    rd(OFS_STATUS, 32'h000040E2, 32'h7FFF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL, 32'((i * 3 + 1) % 4));
      repeat (4) @(posedge clk);
      chk(32'(rail_en.io2), 32'(((i * 3 + 1) % 4) == 2));
    end
    $display("power-up and ldo test done");
    ramp_hold  <= 5'h08;
    enable_pin <= 1'b1;
    wt(3, 1'b1, 2000);
    chk(32'(n + TC >= dl * 2 * TC && n <= dl * 2 * TC + 30), 32'h1);
    repeat (50) @(posedge clk);
    chk(32'(rail_en.gate), 32'h0);
    ramp_hold <= 5'h00;
    wt(4, 1'b1, 10);
    chk(32'(n <= 4), 32'h1);
    rd(OFS_STATUS, 32'h000043E8, 32'h7FFF);
    bus(1'b1, OFS_SOFT, r);
    bus(1'b1, OFS_GATE, r);
    rd(OFS_SOFT, r, 32'h77);
    chk(32'(cfg.logic_rail_softstart_time), 32'(r[2:0]));
    chk(32'(cfg.bias_rail_softstart_time), 32'(r[6:4]));
    chk({cfg.gate_high_cold_target, cfg.gate_high_hot_target}, 32'(r[7:0]));
    bus(1'b1, OFS_DELAY, {21'h0, rc, 8'h7F});
    rd(OFS_DELAY, 32'h46, 32'h7F);
    ramp_hold <= 5'h01;
    repeat (20) @(posedge clk);
    chk(32'(reset_wire), 32'h1);
    ramp_hold <= 5'h00;
    $display("sequencing test done");
    enable_pin <= 1'b0;
    wt(3, 1'b0, 20);
    rd(OFS_STATUS, 32'h3000, 32'h3300);
    enable_pin <= 1'b1;
    bus(1'b1, OFS_STATUS, 32'h0);
    repeat (50) @(posedge clk);
    rd(OFS_STATUS, 32'h3000, 32'h3300);
    bus(1'b1, OFS_CTRL, 32'hE);
    rd(OFS_CTRL, 32'hE, 32'hF);
    chk(32'(cfg.ldo_select), 32'h1);
    above_detect <= 1'b0;
    wt(5, 1'b0, 20);
    chk(32'(n < 20), 32'h1);
    supply_ok <= 1'b0;
    wt(1, 1'b0, 20);
    chk(32'(io1_discharge), 32'h1);
    rd(OFS_STATUS, 32'h1, 32'h1F);
    $display("latch-off and power-down test done");
    pwr_up(3'h0, 7'h00);
    // lockout mode: a low detect level must not pull reset
    above_detect <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(reset_wire), 32'h1);
    above_detect <= 1'b1;
    below70 <= 5'h02;
    repeat (UV_QUAL_TICKS * TC - 3 * TC) @(posedge clk);
    chk(32'(chip_shutdown), 32'h0);
    below70 <= 5'h00;
    repeat (5) @(posedge clk);
    below70 <= 5'h02;
    wt(6, 1'b1, UV_QUAL_TICKS * TC + 50);
    chk(32'(n + TC >= UV_QUAL_TICKS * TC && n < UV_QUAL_TICKS * TC + 50), 32'h1);
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    supply_ok <= 1'b1;
    repeat (10) @(posedge clk);
    rd(OFS_STATUS, 32'h410, 32'hC1F);
    for (int i = 0; i < 3; i++) begin
      pwr_up(3'h1, 7'h00);
      below30 <= 5'(1 << i);
      wt(6, 1'b1, 10);
      chk(32'(n <= 3), 32'h1);
      rd(OFS_STATUS, 32'h810, 32'hC1F);
    end
    $display("fault test done");
    stop_test();
  end
endmodule : lbps_sequencer_tb_top

bind lbps_sequencer lbps_seq_chk #(.TICK_CYC(TICK_CYC)) u_lbps_seq_chk (.clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .ramp_done, .below70, .below30, .reset_line_out, .reset_line_oe,
  .rail_en, .io1_discharge, .chip_shutdown, .cfg);

//--- verif/lbps_tcon_model.sv
`timescale 1ns/1ps
module lbps_tcon_model (
  input  wire logic reset_line_out, // device drive value
  input  wire logic reset_line_oe,  // device pulldown on
  output logic      reset_wire      // pin level at receiver
);
  // external pullup wins when the device lets go
  assign reset_wire = reset_line_oe ? reset_line_out : 1'b1;
endmodule : lbps_tcon_model
